// File: common/gpx_map.svh
// Register indices, field positions, reset values and bus codes of the GPIO expander port block.
// Assumes a 32-bit AXI4-Lite register bus with byte address equal to four times the register index.
//
// How it works
// RQ1 - Reset leaves all pins inputs with pull-down
// RQ2 - Direction, output level and pull-down select per pin
// RQ3 - Host masks interrupts of unused pins
// RQ4 - Host keeps unused input pins from floating
// RQ5 - Interrupt line released, pulled low on condition
// RQ6 - Enables reset masked; host unmasks input pins only
// RQ7 - Write data byte arrives most significant first
// RQ8 - Pins change only after data byte acknowledge
// RQ9 - Write configuration pulse applies value at acknowledge
// RQ10 - Read pulse captures input pins into sample
// RQ11 - Stable pin levels captured and returned on read
// RQ12 - Enabled pin mismatch versus sample pulls interrupt low
// RQ13 - Reading sample register releases the interrupt
// RQ14 - Interrupt follows live pins, not latched
// RQ15 - Any single enabled mismatching pin raises interrupt
// RQ16 - Host keeps last sample to find changes
// RQ17 - Internal power-on reset when reset pin high
// RQ18 - Sample register is read-only, writes ignored
// RQ19 - External reset pin low clears configuration
// RQ20 - Enable register bit n controls pin n
// RQ21 - Open-drain lines only drive low or release
// RQ22 - Pin inputs pass a two-stage synchroniser
`ifndef GPX_MAP_SVH
`define GPX_MAP_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define GPX_IDX_RESET 6'h04
`define GPX_IDX_UNMASK 6'h08
`define GPX_IDX_SAMPLE 6'h10
`define GPX_IDX_OUT 6'h11
`define GPX_IDX_DIR 6'h12
`define GPX_IDX_PD 6'h13

// ==========================================================================
// Fields and reset values
`define GPX_RESET_BIT 7
`define GPX_CFG_INIT 8'h00
`define GPX_SAMPLE_INIT 8'h00

// ==========================================================================
// Bus answer codes
`define GPX_RESP_OKAY 2'h0
`define GPX_RESP_SLVERR 2'h2

`endif

// File: common/gpx_pkg.sv
// Types shared by the GPIO expander port block.
// Assumes the constants of gpx_map.svh are included by each user.
package gpx_pkg;
    // ======================================================================
    // Data types
    typedef logic [7:0] gpx_byte_t;
    typedef logic [31:0] gpx_word_t;
    typedef logic [7:0] gpx_addr_t;
    // Register selected by a bus address
    typedef enum logic [2:0] {
        GPX_SEL_NONE,
        GPX_SEL_RESET,
        GPX_SEL_UNMASK,
        GPX_SEL_SAMPLE,
        GPX_SEL_OUT,
        GPX_SEL_DIR,
        GPX_SEL_PD
    } gpx_sel_e;
endpackage

// File: rtl/gpx_sync.sv
// Two-stage level synchroniser for signals from outside the clock domain.
// Assumes inputs are levels that stay for several clock periods.
`timescale 1ns/1ps
module gpx_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // ======================================================================
    // First stage is read only by the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// File: rtl/gpx_port_irq.sv
// Port and interrupt logic of an eight-pin GPIO expander behind an AXI4-Lite slave.
// Assumes the bus master follows AXI4-Lite and pins settle outside the clock domain.
`timescale 1ns/1ps
`include "gpx_map.svh"
module gpx_port_irq
    import gpx_pkg::*;
(
    // Clock and power-on reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // External reset pin
    input wire logic EXT_RST_N_I,
    // GPIO pins
    input wire logic [7:0] GPIO_I,
    output logic [7:0] GPIO_O,
    output logic [7:0] GPIO_OE_N_O,
    output logic [7:0] GPIO_PD_EN_O,
    // Open-drain interrupt line
    output logic IRQ_N_OUT_O,
    output logic IRQ_N_OUT_OE_N_O,
    // AXI4-Lite write address and data
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);

    // ======================================================================
    // Declarations
    gpx_byte_t pin_sync;
    logic ext_rst_n;
    gpx_byte_t irq_unmask_reg;
    gpx_byte_t out_value_reg;
    gpx_byte_t dir_sel_reg;
    gpx_byte_t pulldown_off_reg;
    gpx_byte_t in_sample_reg;
    gpx_byte_t in_sample_next;
    gpx_byte_t cap_value;
    logic irq_out_reg;
    logic aw_held_reg;
    logic w_held_reg;
    gpx_addr_t awaddr_reg;
    gpx_byte_t wdata_reg;
    logic wstrb0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    gpx_byte_t rdata_reg;
    gpx_sel_e wr_sel;
    gpx_sel_e rd_sel;
    logic wr_fire;
    logic rd_fire;
    logic wr_pulse;
    logic rd_pulse;
    logic soft_reset;
    logic cfg_clear;
    gpx_byte_t mismatch;
    logic irq_cond;
    gpx_byte_t rd_byte;

    // ======================================================================
    // Input synchronisers
    // Pins and the reset pin are asynchronous to the core clock
    gpx_sync #(
        .WIDTH(8),
        .INIT(`GPX_SAMPLE_INIT)
    ) u_pin_sync (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .async_i(GPIO_I),
        .sync_o(pin_sync)
    ); // [RQ22]

    // Reset pin reads as asserted until two edges after power-on release
    gpx_sync #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_rst_sync (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RST_N_I),
        .async_i(EXT_RST_N_I),
        .sync_o(ext_rst_n)
    );

    // ======================================================================
    // Address decode
    // Only the register index is decoded; byte offset bits are ignored
    assign wr_sel = (awaddr_reg[7:2] == `GPX_IDX_RESET) ? GPX_SEL_RESET :
                    (awaddr_reg[7:2] == `GPX_IDX_UNMASK) ? GPX_SEL_UNMASK :
                    (awaddr_reg[7:2] == `GPX_IDX_SAMPLE) ? GPX_SEL_SAMPLE :
                    (awaddr_reg[7:2] == `GPX_IDX_OUT) ? GPX_SEL_OUT :
                    (awaddr_reg[7:2] == `GPX_IDX_DIR) ? GPX_SEL_DIR :
                    (awaddr_reg[7:2] == `GPX_IDX_PD) ? GPX_SEL_PD : GPX_SEL_NONE;
    assign rd_sel = (S_AXI_ARADDR_I[7:2] == `GPX_IDX_RESET) ? GPX_SEL_RESET :
                    (S_AXI_ARADDR_I[7:2] == `GPX_IDX_UNMASK) ? GPX_SEL_UNMASK :
                    (S_AXI_ARADDR_I[7:2] == `GPX_IDX_SAMPLE) ? GPX_SEL_SAMPLE :
                    (S_AXI_ARADDR_I[7:2] == `GPX_IDX_OUT) ? GPX_SEL_OUT :
                    (S_AXI_ARADDR_I[7:2] == `GPX_IDX_DIR) ? GPX_SEL_DIR :
                    (S_AXI_ARADDR_I[7:2] == `GPX_IDX_PD) ? GPX_SEL_PD : GPX_SEL_NONE;

    // ======================================================================
    // Bus handshakes
    // A write fires once both halves are held and no response is pending
    assign S_AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY_O = !w_held_reg && !bvalid_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign S_AXI_ARREADY_O = !rvalid_reg;
    assign rd_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    // Configuration pulses; the bus response stands in for the acknowledge
    // Writes are answered but not applied while the reset pin holds the block in power down
    assign wr_pulse = wr_fire && wstrb0_reg && ext_rst_n; // [RQ9] [RQ7]
    assign rd_pulse = rd_fire && (rd_sel == GPX_SEL_SAMPLE) && ext_rst_n; // [RQ10]
    assign soft_reset = wr_pulse && (wr_sel == GPX_SEL_RESET) && wdata_reg[`GPX_RESET_BIT];
    assign cfg_clear = !ext_rst_n || soft_reset; // [RQ19]

    // ======================================================================
    // Write address and data holding
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR_I;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held_reg <= 1'b1;
            wdata_reg <= S_AXI_WDATA_I[7:0];
            wstrb0_reg <= S_AXI_WSTRB_I[0];
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Write response; unmapped indices answer with a slave error
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `GPX_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == GPX_SEL_NONE) ? `GPX_RESP_SLVERR : `GPX_RESP_OKAY;
        end else if (S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_BVALID_O = bvalid_reg;
    assign S_AXI_BRESP_O = bresp_reg;

    // ======================================================================
    // Configuration registers
    // All clear at power-on, reset pin low or a soft reset write
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_unmask_reg <= `GPX_CFG_INIT; // [RQ6] [RQ17]
            out_value_reg <= `GPX_CFG_INIT;
            dir_sel_reg <= `GPX_CFG_INIT; // [RQ1]
            pulldown_off_reg <= `GPX_CFG_INIT; // [RQ1]
        end else if (cfg_clear) begin
            irq_unmask_reg <= `GPX_CFG_INIT; // [RQ19]
            out_value_reg <= `GPX_CFG_INIT;
            dir_sel_reg <= `GPX_CFG_INIT;
            pulldown_off_reg <= `GPX_CFG_INIT;
        end else if (wr_pulse) begin
            // New values reach the pins only at the configuration pulse
            if (wr_sel == GPX_SEL_UNMASK) irq_unmask_reg <= wdata_reg; // [RQ20] [RQ8]
            if (wr_sel == GPX_SEL_OUT) out_value_reg <= wdata_reg; // [RQ8]
            if (wr_sel == GPX_SEL_DIR) dir_sel_reg <= wdata_reg; // [RQ8]
            if (wr_sel == GPX_SEL_PD) pulldown_off_reg <= wdata_reg; // [RQ8]
        end
    end

    // ======================================================================
    // Input sample capture
    // Output-configured pins keep their last sampled bit
    generate
        for (genvar n = 0; n < 8; n++) begin : g_pin
            assign cap_value[n] = dir_sel_reg[n] ? in_sample_reg[n] : pin_sync[n]; // [RQ10]
            assign GPIO_OE_N_O[n] = ~dir_sel_reg[n]; // [RQ2] [RQ21]
            assign GPIO_PD_EN_O[n] = ~dir_sel_reg[n] & ~pulldown_off_reg[n]; // [RQ2]
            assign mismatch[n] = irq_unmask_reg[n] & (pin_sync[n] ^ in_sample_reg[n]); // [RQ12]
        end
    endgenerate

    // Soft reset leaves the sample alone; writes to it never land
    assign in_sample_next = !ext_rst_n ? `GPX_SAMPLE_INIT :
                            rd_pulse ? cap_value : in_sample_reg; // [RQ18] [RQ11]

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            in_sample_reg <= `GPX_SAMPLE_INIT; // [RQ12]
        end else begin
            in_sample_reg <= in_sample_next;
        end
    end

    // ======================================================================
    // Read channel
    // The sample read returns the value captured at this very edge
    assign rd_byte = (rd_sel == GPX_SEL_UNMASK) ? irq_unmask_reg :
                     (rd_sel == GPX_SEL_SAMPLE) ? in_sample_next :
                     (rd_sel == GPX_SEL_OUT) ? out_value_reg :
                     (rd_sel == GPX_SEL_DIR) ? dir_sel_reg :
                     (rd_sel == GPX_SEL_PD) ? pulldown_off_reg : 8'h00;

    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rresp_reg <= `GPX_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_byte; // [RQ11]
            rresp_reg <= (rd_sel == GPX_SEL_NONE) ? `GPX_RESP_SLVERR : `GPX_RESP_OKAY;
        end else if (S_AXI_RREADY_I) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign S_AXI_RVALID_O = rvalid_reg;
    assign S_AXI_RRESP_O = rresp_reg;
    assign S_AXI_RDATA_O = {24'h000000, rdata_reg};

    // ======================================================================
    // Pin drive and interrupt
    // Output level comes straight from its register
    assign GPIO_O = out_value_reg; // [RQ2]

    // Live comparison, so the line releases if pins revert without a read
    assign irq_cond = |mismatch; // [RQ15] [RQ14]

    // Registered so the line is glitch free; adds one cycle of latency
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_out_reg <= 1'b0; // [RQ5]
        end else begin
            irq_out_reg <= irq_cond; // [RQ12] [RQ13]
        end
    end

    // Open drain: the data is always low and only the enable moves
    assign IRQ_N_OUT_O = 1'b0; // [RQ21]
    assign IRQ_N_OUT_OE_N_O = ~irq_out_reg; // [RQ5]

    // ======================================================================
    // Assertions
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);

    // A write pulse to the direction register that no configuration clear overrides
    sequence s_dir_write;
        wr_pulse && (wr_sel == GPX_SEL_DIR) && !cfg_clear;
    endsequence

    sequence s_sample_read;
        rd_pulse ##1 $stable(pin_sync) && $stable(irq_unmask_reg);
    endsequence

    a_dir_write_apply: assert property ( // [RQ9]
        s_dir_write |=> (GPIO_OE_N_O == ~$past(wdata_reg)) && S_AXI_BVALID_O)
        else $error("direction write not applied with its response");

    a_pins_hold_still: assert property ( // [RQ8]
        !wr_pulse && !cfg_clear |=> $stable(GPIO_O) && $stable(GPIO_OE_N_O))
        else $error("pin drive changed without a configuration pulse");

    a_pulldown_input_only: assert property ( // [RQ2]
        (GPIO_PD_EN_O & ~GPIO_OE_N_O) == 8'h00)
        else $error("pull-down enabled on a driven pin");

    a_ext_reset_clear: assert property ( // [RQ19]
        !ext_rst_n |=> (irq_unmask_reg == 8'h00) && (dir_sel_reg == 8'h00)
                       && (GPIO_PD_EN_O == 8'hff) && (out_value_reg == 8'h00))
        else $error("reset pin did not clear configuration");

    a_sample_read_only: assert property ( // [RQ18]
        wr_fire && (wr_sel == GPX_SEL_SAMPLE) && !rd_pulse && ext_rst_n |=> $stable(in_sample_reg))
        else $error("sample register changed on a write");

    a_read_capture: assert property ( // [RQ10]
        rd_pulse |=> (in_sample_reg == $past(cap_value)) && S_AXI_RVALID_O
                     && (S_AXI_RDATA_O[7:0] == in_sample_reg))
        else $error("sample read did not return the captured pins");

    a_irq_follows_pins: assert property ( // [RQ14]
        irq_cond |=> !IRQ_N_OUT_OE_N_O)
        else $error("interrupt not asserted for a standing mismatch");

    a_irq_released: assert property ( // [RQ12]
        !irq_cond |=> IRQ_N_OUT_OE_N_O)
        else $error("interrupt driven with no enabled mismatch");

    a_read_releases_irq: assert property ( // [RQ13]
        s_sample_read ##0 ($past(dir_sel_reg & irq_unmask_reg) == 8'h00) |-> ##[1:2] IRQ_N_OUT_OE_N_O)
        else $error("sample read did not release the interrupt");

    a_irq_no_high: assert property ( // [RQ21]
        IRQ_N_OUT_O == 1'b0 && $stable(IRQ_N_OUT_O))
        else $error("interrupt line driven high");

    a_write_answer: assert property (
        wr_fire |=> S_AXI_BVALID_O [*1] ##0 !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write not answered in one cycle");

    // Output-configured pins keep their sampled bit across a capture
    a_output_bit_kept: assert property ( // [RQ10]
        rd_pulse |=> ((in_sample_reg ^ $past(in_sample_reg)) & $past(dir_sel_reg)) == 8'h00)
        else $error("sample bit of a driven pin changed on capture");

    // Unmapped writes are answered with an error and change nothing
    a_unmapped_write: assert property (
        wr_fire && (wr_sel == GPX_SEL_NONE) && ext_rst_n
        |=> (S_AXI_BRESP_O == `GPX_RESP_SLVERR) && $stable(out_value_reg))
        else $error("unmapped write not refused");

    // A write without byte lane 0 leaves the port alone
    a_strobe_ignored: assert property (
        wr_fire && !wstrb0_reg && !cfg_clear |=> $stable(out_value_reg) && $stable(dir_sel_reg))
        else $error("write without lane 0 strobe changed the port");
endmodule

// File: dv/gpx_pin_model.sv
// Board side of the expander pins: pad resolution and the pulled-up interrupt line.
// Assumes board drivers are enabled only on pins that the design leaves released.
`timescale 1ns/1ps
module gpx_pin_model (
    // Clock for the floating pattern
    input wire logic clk_i,
    // Design pin controls
    input wire logic [7:0] gpio_o_i,
    input wire logic [7:0] gpio_oe_n_i,
    input wire logic [7:0] pd_en_i,
    input wire logic irq_o_i,
    input wire logic irq_oe_n_i,
    // Board drivers
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    // Resolved levels
    output logic [7:0] pad_o,
    output logic irq_line_o
);
    // ==========================================================================
    // Pads: design drive, board drive, pull-down, else a toggling level
    // A floating pad flips every half cycle so a stale value never passes as real
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (!gpio_oe_n_i[n]) begin
                pad_o[n] = gpio_o_i[n];
            end else if (ext_en_i[n]) begin
                pad_o[n] = ext_val_i[n];
            end else if (pd_en_i[n]) begin
                pad_o[n] = 1'b0;
            end else begin
                pad_o[n] = clk_i ^ n[0];
            end
        end
    end
    // Open drain with board pull-up: only a low can come from the design
    assign irq_line_o = irq_oe_n_i ? 1'b1 : irq_o_i;
endmodule

// File: dv/gpx_port_irq_tb.sv
// Self-checking bench of the expander port block over AXI4-Lite.
// Assumes the pin model resolves pads and the interrupt line.
`timescale 1ns/1ps
`include "gpx_map.svh"
module gpx_port_irq_tb;
    import gpx_pkg::*;
    // ==========================================================================
    // Signals
    logic clk, rst_n, ext_rst_n, aw_v, w_v, b_r, ar_v, r_r, irq_o, irq_oe_n, irq_line;
    logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic [1:0] b_resp, r_resp;
    logic [7:0] ext_val, ext_en, pad, g_o, g_oe_n, g_pd, aw_a, ar_a, prev;
    logic [31:0] w_d, r_d;
    logic [3:0] w_s;
    int bad_count, samples_checked;
    localparam logic [7:0] A_RST = {`GPX_IDX_RESET, 2'b00};
    localparam logic [7:0] A_MSK = {`GPX_IDX_UNMASK, 2'b00};
    localparam logic [7:0] A_SMP = {`GPX_IDX_SAMPLE, 2'b00};
    localparam logic [7:0] A_OUT = {`GPX_IDX_OUT, 2'b00};
    localparam logic [7:0] A_DIR = {`GPX_IDX_DIR, 2'b00};
    localparam logic [7:0] A_PD = {`GPX_IDX_PD, 2'b00};
    // ==========================================================================
    // Design and board
    gpx_port_irq uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .EXT_RST_N_I(ext_rst_n), .GPIO_I(pad),
        .GPIO_O(g_o), .GPIO_OE_N_O(g_oe_n), .GPIO_PD_EN_O(g_pd), .IRQ_N_OUT_O(irq_o),
        .IRQ_N_OUT_OE_N_O(irq_oe_n), .S_AXI_AWADDR_I(aw_a), .S_AXI_AWVALID_I(aw_v),
        .S_AXI_AWREADY_O(aw_rdy), .S_AXI_WDATA_I(w_d), .S_AXI_WSTRB_I(w_s), .S_AXI_WVALID_I(w_v),
        .S_AXI_WREADY_O(w_rdy), .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(b_r),
        .S_AXI_ARADDR_I(ar_a), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_rdy),
        .S_AXI_RDATA_O(r_d), .S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_r));
    gpx_pin_model board (.clk_i(clk), .gpio_o_i(g_o), .gpio_oe_n_i(g_oe_n), .pd_en_i(g_pd),
        .irq_o_i(irq_o), .irq_oe_n_i(irq_oe_n), .ext_val_i(ext_val), .ext_en_i(ext_en),
        .pad_o(pad), .irq_line_o(irq_line));
    // ==========================================================================
    // Clock, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ==========================================================================
    // Report and compare
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic stall(input string what);
        bad_count++;
        $display("wrong value %s expected answer seen timeout", what);
        complete_run();
    endtask
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ==========================================================================
    // Bus tasks: handshakes are judged at the falling edge, acted on at the rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = `GPX_RESP_OKAY);
        logic aw_p, w_p, a_t, w_t;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge clk);
        aw_a <= a;
        aw_v <= 1'b1;
        w_d <= {24'h0, d};
        w_v <= 1'b1;
        b_r <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            a_t = aw_p & aw_rdy;
            w_t = w_p & w_rdy;
            if (b_v === 1'b1) begin
                check_word("write resp", {30'h0, er}, {30'h0, b_resp});
                @(posedge clk);
                b_r <= 1'b0;
                return;
            end
            @(posedge clk);
            if (a_t) begin
                aw_p = 1'b0;
                aw_v <= 1'b0;
            end
            if (w_t) begin
                w_p = 1'b0;
                w_v <= 1'b0;
            end
        end
        stall("write answer");
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic ar_p;
        ar_p = 1'b1;
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (r_v === 1'b1) begin
                check_word(what, {24'h0, exp}, r_d);
                check_word("read resp", {30'h0, er}, {30'h0, r_resp});
                @(posedge clk);
                r_r <= 1'b0;
                return;
            end
            ar_p = ar_p & ~ar_rdy;
            @(posedge clk);
            if (!ar_p) begin
                ar_v <= 1'b0;
            end
        end
        stall("read answer");
    endtask
    // ==========================================================================
    // Pin and interrupt helpers
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 12; i++) begin
            @(negedge clk);
            if (irq_line === lvl) begin
                break;
            end
        end
        check_word("interrupt line", {31'h0, lvl}, {31'h0, irq_line});
        if (irq_line !== lvl) begin
            stall("interrupt line");
        end
    endtask
    task automatic look(input logic [7:0] oe, input logic [7:0] pd, input logic [7:0] o);
        @(negedge clk);
        check_word("pin drive enables", {24'h0, oe}, {24'h0, g_oe_n});
        check_word("pull-down enables", {24'h0, pd}, {24'h0, g_pd});
        check_word("pin outputs", {24'h0, o}, {24'h0, g_o});
    endtask
    // ==========================================================================
    // Main sequence
    initial begin
        {rst_n, aw_v, w_v, b_r, ar_v, r_r} = '0;
        {aw_a, ar_a, w_d, ext_val} = '0;
        w_s = 4'h1;
        ext_rst_n = 1'b1;
        ext_en = 8'hff;
        bad_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        look(8'hff, 8'hff, 8'h00);
        check_word("interrupt line", 32'h1, {31'h0, irq_line});
        check_word("interrupt data", 32'h0, {31'h0, irq_o});
        rd("unmask", A_MSK, 8'h00, `GPX_RESP_OKAY);
        rd("sample", A_SMP, 8'h00, `GPX_RESP_OKAY);
        rd("direction", A_DIR, 8'h00, `GPX_RESP_OKAY);
        rd("pull-down off", A_PD, 8'h00, `GPX_RESP_OKAY);
        rd("unmapped", 8'h00, 8'h00, `GPX_RESP_SLVERR);
        wr(8'h00, 8'h00, `GPX_RESP_SLVERR);
        // Low nibble outputs, pins 4 and 5 pull-down off but board driven
        @(posedge clk);
        ext_en <= 8'hf0;
        ext_val <= 8'h10;
        wr(A_DIR, 8'h0f);
        wr(A_OUT, 8'h05);
        wr(A_PD, 8'h30);
        look(8'hf0, 8'hc0, 8'h05);
        repeat (4) @(posedge clk);
        rd("sample", A_SMP, 8'h10, `GPX_RESP_OKAY);
        wr(A_SMP, 8'hff);
        rd("sample", A_SMP, 8'h10, `GPX_RESP_OKAY);
        // Host masks the output pins and keeps its own copy of the sample
        wr(A_MSK, 8'hf0);
        prev = 8'h10;
        for (int n = 4; n < 8; n++) begin
            @(posedge clk);
            ext_val <= ext_val ^ (8'h01 << n);
            @(negedge clk);
            @(negedge clk);
            check_word("interrupt line", 32'h1, {31'h0, irq_line});
            wait_irq(1'b0);
            @(posedge clk);
            ext_val <= ext_val ^ (8'h01 << n);
            wait_irq(1'b1);
            @(posedge clk);
            ext_val <= ext_val ^ (8'h01 << n);
            wait_irq(1'b0);
            prev = prev ^ (8'h01 << n);
            rd("sample", A_SMP, prev, `GPX_RESP_OKAY);
            wait_irq(1'b1);
        end
        // Only pin 7 unmasked: a change on pin 4 stays silent
        wr(A_MSK, 8'h80);
        @(posedge clk);
        ext_val <= ext_val ^ 8'h10;
        repeat (6) @(negedge clk);
        check_word("masked interrupt", 32'h1, {31'h0, irq_line});
        rd("sample", A_SMP, prev ^ 8'h10, `GPX_RESP_OKAY);
        // Soft reset returns the pins to inputs with pull-down
        wr(A_RST, 8'h80);
        look(8'hff, 8'hff, 8'h00);
        rd("reset reg", A_RST, 8'h00, `GPX_RESP_OKAY);
        rd("unmask", A_MSK, 8'h00, `GPX_RESP_OKAY);
        // A write without lane 0 strobe is answered but not applied
        w_s <= 4'h0;
        wr(A_OUT, 8'h3c);
        w_s <= 4'h1;
        rd("output value", A_OUT, 8'h00, `GPX_RESP_OKAY);
        // External reset pin clears and holds the configuration
        wr(A_DIR, 8'hff);
        wr(A_OUT, 8'ha5);
        look(8'h00, 8'h00, 8'ha5);
        @(posedge clk);
        ext_rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        look(8'hff, 8'hff, 8'h00);
        wr(A_OUT, 8'hff);
        rd("sample", A_SMP, 8'h00, `GPX_RESP_OKAY);
        @(posedge clk);
        ext_rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd("output value", A_OUT, 8'h00, `GPX_RESP_OKAY);
        rd("direction", A_DIR, 8'h00, `GPX_RESP_OKAY);
        complete_run();
    end
endmodule
